// ---- rtl/obdp_top.sv ----
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module obdp_top #(
   parameter int unsigned COUNT_W = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic msg_valid,
   output logic msg_ready,
   input wire obdp_pkg::obdp_msg_s msg,
   output logic wb_valid,
   input wire logic wb_ready,
   output obdp_pkg::obdp_wb_s wb,
   output logic done_valid,
   output obdp_pkg::obdp_done_s done,
   output logic mem_req_valid,
   input wire logic mem_req_ready,
   output obdp_pkg::obdp_mem_req_s mem_req,
   input wire logic mem_rvalid,
   input wire logic [127:0] mem_rdata,
   input wire obdp_pkg::obdp_apb_req_s apb_req,
   output obdp_pkg::obdp_apb_rsp_s apb_rsp
);
   import obdp_pkg::*;

   if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
      $error("COUNT_W must lie between 1 and 32.");
   end

   typedef struct packed {
      obdp_phase_e phase;
      obdp_msg_s msg;
      logic [3:0] k;
      logic [255:0] wbuf;
      logic [7:0] wen;
      logic lo_ok;
      logic last;
      logic req_valid;
      obdp_mem_req_s req;
      logic wb_valid;
      obdp_wb_s wb;
      logic done_valid;
      obdp_done_s done;
      logic [31:0] surf_base;
      logic [31:0] surf_elems;
      logic [COUNT_W-1:0] count;
      logic last_err;
      logic [31:0] prdata;
      logic pslverr;
   } obdp_state_s;

   obdp_state_s st;
   obdp_state_s next_st;

   obdp_op_e op;
   logic [3:0] n_ow;
   logic hi_start;
   logic dec_err;
   logic [31:0] ag_addr;
   logic [3:0] acc_en;
   logic [3:0] dest_en;
   logic half;
   logic [1:0] reg_idx;
   logic [31:0] off0;
   logic [31:0] off1;
   logic is_wr;
   logic place;
   logic [127:0] pdata;
   logic reuse;
   logic final_ow;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [2:0] wreg;

   // Dual offsets sit in the first and fifth DWords of the first payload.
   assign off0 = st.msg.payload[0][BLK_OFF0_LSB +: 32];
   assign off1 = st.msg.payload[0][BLK_OFF1_LSB +: 32];

   obdp_decode u_decode (
      .desc(st.msg.desc),
      .op(op),
      .n_ow(n_ow),
      .hi_start(hi_start),
      .err(dec_err)
   );

   obdp_addr_gen u_addr_gen (
      .op(op),
      .hi_start(hi_start),
      .k(st.k[2:0]),
      .global_off(st.msg.global_off),
      .off0(off0),
      .off1(off1),
      .exec_mask(st.msg.exec_mask),
      .base(st.surf_base),
      .elems(st.surf_elems),
      .addr(ag_addr),
      .acc_en(acc_en),
      .dest_en(dest_en),
      .half(half),
      .reg_idx(reg_idx)
   );

   function automatic logic [127:0] keep_dwords(
      input logic [127:0] d,
      input logic [3:0] en
   );
      logic [127:0] r;
      r = 128'h0;
      for (int j = 0; j < 4; j++) begin
         if (en[j]) begin
            r[j*32 +: 32] = d[j*32 +: 32];
         end
      end
      return r;
   endfunction

   always_comb begin
      next_st = st;
      is_wr = (op == OP_BLK_WR) || (op == OP_DUAL_WR);
      place = 1'b0;
      pdata = 128'h0;
      reuse = (op == OP_DUAL_RD) && half && (off0 == off1) && st.lo_ok;
      final_ow = (st.k == n_ow - 4'h1);
      rd_word = 32'h0;
      rd_hit = 1'b1;
      // Dual writes carry their data in the registers after the offsets,
      // so their write register index is one above the writeback index.
      if (op == OP_DUAL_WR) begin
         wreg = 3'(reg_idx) + 3'h1;
      end else begin
         wreg = 3'(reg_idx);
      end
      next_st.done_valid = 1'b0;

      case (st.phase)
         PH_IDLE: begin
            if (msg_valid) begin
               next_st.msg = msg;
               next_st.k = 4'h0;
               next_st.wbuf = 256'h0;
               next_st.wen = 8'h0;
               next_st.lo_ok = 1'b0;
               next_st.phase = PH_ISSUE;
            end
         end
         PH_ISSUE: begin
            if (dec_err) begin
               next_st.done.err = 1'b1;
               next_st.done.commit = 1'b0;
               next_st.done_valid = 1'b1;
               next_st.phase = PH_DONE;
            end else if (reuse) begin
               // The second block shares the low half's single fetch.
               place = 1'b1;
               pdata = st.wbuf[127:0];
            end else if (acc_en == 4'h0) begin
               // Nothing to move; a read still writes zeros where enabled.
               place = 1'b1;
               // A skipped low half leaves no fetch for the high half to share.
               next_st.lo_ok = 1'b0;
            end else begin
               next_st.req_valid = 1'b1;
               next_st.req.we = is_wr;
               next_st.req.addr = ag_addr;
               next_st.req.dw_en = acc_en;
               // Raw payload bits go straight out, with no conversion.
               next_st.req.wdata = is_wr ?
                  st.msg.payload[wreg][half*128 +: 128] : 128'h0;
               next_st.phase = PH_REQ;
            end
         end
         PH_REQ: begin
            if (mem_req_ready) begin
               next_st.req_valid = 1'b0;
               if (st.req.we) begin
                  place = 1'b1;
               end else begin
                  next_st.phase = PH_RESP;
               end
            end
         end
         PH_RESP: begin
            if (mem_rvalid) begin
               place = 1'b1;
               pdata = keep_dwords(mem_rdata, st.req.dw_en);
               if (op == OP_DUAL_RD && !half) begin
                  next_st.lo_ok = 1'b1;
               end
            end
         end
         PH_WB: begin
            if (wb_ready) begin
               next_st.wb_valid = 1'b0;
               next_st.wbuf = 256'h0;
               next_st.wen = 8'h0;
               if (st.last) begin
                  next_st.done.err = 1'b0;
                  next_st.done.commit = 1'b0;
                  next_st.done_valid = 1'b1;
                  next_st.phase = PH_DONE;
               end else begin
                  next_st.k = st.k + 4'h1;
                  next_st.phase = PH_ISSUE;
               end
            end
         end
         PH_DONE: begin
            next_st.last_err = st.done.err;
            next_st.count = st.count + COUNT_W'(1);
            next_st.phase = PH_IDLE;
         end
         default: next_st.phase = PH_IDLE;
      endcase

      if (place) begin
         if (is_wr) begin
            if (final_ow) begin
               next_st.done.err = 1'b0;
               next_st.done.commit = st.msg.desc[COMMIT_BIT];
               next_st.done_valid = 1'b1;
               next_st.phase = PH_DONE;
            end else begin
               next_st.k = st.k + 4'h1;
               next_st.phase = PH_ISSUE;
            end
         end else begin
            // Only enabled DWords reach the destination; a single OWord
            // leaves the other half untouched.
            next_st.wbuf[half*128 +: 128] = pdata;
            next_st.wen[half*4 +: 4] = dest_en;
            if (half || final_ow) begin
               next_st.wb_valid = 1'b1;
               next_st.wb.idx = reg_idx;
               next_st.wb.data = next_st.wbuf;
               next_st.wb.dw_en = next_st.wen;
               next_st.last = final_ow;
               next_st.phase = PH_WB;
            end else begin
               next_st.k = st.k + 4'h1;
               next_st.phase = PH_ISSUE;
            end
         end
      end

      case (apb_req.paddr)
         REG_SURF_BASE: rd_word = st.surf_base;
         REG_SURF_ELEMS: rd_word = st.surf_elems;
         REG_STATUS: rd_word = {30'h0, st.last_err, st.phase != PH_IDLE};
         REG_MSG_COUNT: rd_word = 32'(st.count);
         default: rd_hit = 1'b0;
      endcase
      if (apb_req.psel && !apb_req.penable) begin
         next_st.prdata = apb_req.pwrite ? 32'h0 : rd_word;
         next_st.pslverr = !rd_hit;
      end
      if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
         if (apb_req.paddr == REG_SURF_BASE) begin
            next_st.surf_base = {apb_req.pwdata[31:4], 4'h0};
         end
         if (apb_req.paddr == REG_SURF_ELEMS) begin
            next_st.surf_elems = apb_req.pwdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
         st.phase <= PH_IDLE;
         st.surf_base <= SURF_BASE_RST;
         st.surf_elems <= SURF_ELEMS_RST;
      end else begin
         st <= next_st;
      end
   end

   assign msg_ready = (st.phase == PH_IDLE);
   assign wb_valid = st.wb_valid;
   assign wb = st.wb;
   assign done_valid = st.done_valid;
   assign done = st.done;
   assign mem_req_valid = st.req_valid;
   assign mem_req = st.req;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.prdata = st.prdata;
   assign apb_rsp.pslverr = st.pslverr;
endmodule

// ---- include/obdp_pkg.sv ----
// Overview of operation
// - Block size 000/001 one OWord low/high half, 010 two, 011 four, 100 eight.
// - Aligned write takes one, two or four payload registers, even OWord low.
// - Single high-half write takes upper 128 bits and ignores lower half.
// - Aligned read returns registers paired low/high; single OWord fills one half.
// - Unaligned read fetches consecutive OWords; high code puts first OWord high.
// - Unaligned global offset is a DWord-aligned byte address.
// - Unaligned access exists only on the read path.
// - No format conversion; surface treated as one-dimensional raw data.
// - Bounds use a fixed element size of sixteen bytes.
// - Unaligned read ignores the execution mask.
// - Out-of-bounds read parts return zero.
// - Out-of-bounds write data is discarded.
// - Dual block adds global offset to each block offset, one or four OWords.
// - Equal dual read indices use one cache access for both blocks.
// - Dual read uses low eight mask bits; any bit in four reads OWord.
// - Dual write stores each DWord only when its mask bit is set.
// - Dual block size 00 is one OWord, 10 is four, others reserved.
// - Dual offsets come from first and fifth DWords of first payload.
// - Write commit answer only when descriptor asks; otherwise nothing returns. Here done always pulses, with commit clear when not asked.
package obdp_pkg;
   localparam int BLK_SIZE_LSB = 8;
   localparam int MSG_TYPE_LSB = 13;
   localparam int COMMIT_BIT = 17;
   localparam int BLK_OFF1_LSB = 128;
   localparam int BLK_OFF0_LSB = 0;
   localparam logic [2:0] BS_ONE_LO = 3'h0;
   localparam logic [2:0] BS_ONE_HI = 3'h1;
   localparam logic [2:0] BS_TWO = 3'h2;
   localparam logic [2:0] BS_FOUR = 3'h3;
   localparam logic [2:0] BS_EIGHT = 3'h4;
   localparam logic [1:0] DBS_ONE = 2'h0;
   localparam logic [1:0] DBS_FOUR = 2'h2;
   localparam logic [3:0] MT_BLK_RD = 4'h0;
   localparam logic [3:0] MT_DUAL_RD = 4'h2;
   localparam logic [3:0] MT_UNAL_RD = 4'h5;
   localparam logic [3:0] MT_BLK_WR = 4'h8;
   localparam logic [3:0] MT_DUAL_WR = 4'h9;
   localparam logic [3:0] ELEM_SHIFT = 4'h4;
   localparam logic [11:0] REG_SURF_BASE = 12'h000;
   localparam logic [11:0] REG_SURF_ELEMS = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_MSG_COUNT = 12'h00C;
   localparam logic [31:0] SURF_BASE_RST = 32'h0000_0000;
   localparam logic [31:0] SURF_ELEMS_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      OP_NONE, OP_BLK_RD, OP_UNAL_RD, OP_DUAL_RD, OP_BLK_WR, OP_DUAL_WR
   } obdp_op_e;

   typedef enum logic [2:0] {
      PH_IDLE, PH_ISSUE, PH_REQ, PH_RESP, PH_WB, PH_DONE
   } obdp_phase_e;

   typedef struct packed {
      logic [19:0] desc;
      logic [31:0] global_off;
      logic [15:0] exec_mask;
      logic [4:0][255:0] payload;
   } obdp_msg_s;

   typedef struct packed {
      logic [1:0] idx;
      logic [255:0] data;
      logic [7:0] dw_en;
   } obdp_wb_s;

   typedef struct packed {
      logic commit;
      logic err;
   } obdp_done_s;

   typedef struct packed {
      logic we;
      logic [31:0] addr;
      logic [127:0] wdata;
      logic [3:0] dw_en;
   } obdp_mem_req_s;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } obdp_apb_req_s;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } obdp_apb_rsp_s;
endpackage

// ---- rtl/obdp_decode.sv ----
`timescale 1ns/1ps
module obdp_decode (
   input wire logic [19:0] desc,
   output obdp_pkg::obdp_op_e op,
   output logic [3:0] n_ow,
   output logic hi_start,
   output logic err
);
   import obdp_pkg::*;

   logic [3:0] mtype;
   logic [2:0] bsize;
   logic [1:0] dsize;

   always_comb begin
      mtype = desc[MSG_TYPE_LSB +: 4];
      bsize = desc[BLK_SIZE_LSB +: 3];
      dsize = desc[BLK_SIZE_LSB +: 2];
      op = OP_NONE;
      n_ow = 4'h0;
      hi_start = 1'b0;
      err = 1'b0;
      // An unaligned write type is not decoded and ends as an error.
      case (mtype)
         MT_BLK_RD: op = OP_BLK_RD;
         MT_UNAL_RD: op = OP_UNAL_RD;
         MT_BLK_WR: op = OP_BLK_WR;
         MT_DUAL_RD: op = OP_DUAL_RD;
         MT_DUAL_WR: op = OP_DUAL_WR;
         default: err = 1'b1;
      endcase
      if (op == OP_DUAL_RD || op == OP_DUAL_WR) begin
         // Both blocks are counted, so one OWord per block is two in total.
         case (dsize)
            DBS_ONE: n_ow = 4'h2;
            DBS_FOUR: n_ow = 4'h8;
            default: err = 1'b1;
         endcase
         if (desc[BLK_SIZE_LSB + 2]) begin
            err = 1'b1;
         end
      end else if (op != OP_NONE) begin
         case (bsize)
            BS_ONE_LO: n_ow = 4'h1;
            BS_ONE_HI: begin
               n_ow = 4'h1;
               hi_start = 1'b1;
            end
            BS_TWO: n_ow = 4'h2;
            BS_FOUR: n_ow = 4'h4;
            BS_EIGHT: n_ow = 4'h8;
            default: err = 1'b1;
         endcase
      end
   end
endmodule

// ---- rtl/obdp_addr_gen.sv ----
`timescale 1ns/1ps
module obdp_addr_gen (
   input wire obdp_pkg::obdp_op_e op,
   input wire logic hi_start,
   input wire logic [2:0] k,
   input wire logic [31:0] global_off,
   input wire logic [31:0] off0,
   input wire logic [31:0] off1,
   input wire logic [15:0] exec_mask,
   input wire logic [31:0] base,
   input wire logic [31:0] elems,
   output logic [31:0] addr,
   output logic [3:0] acc_en,
   output logic [3:0] dest_en,
   output logic half,
   output logic [1:0] reg_idx
);
   import obdp_pkg::*;

   logic [3:0] pos;
   logic [35:0] ow;
   logic [39:0] rel;
   logic [39:0] limit;
   logic [3:0] grp;
   logic [3:0] inb;

   always_comb begin
      limit = {4'h0, elems, 4'h0};
      pos = 4'(k) + 4'(hi_start);
      ow = 36'h0;
      rel = 40'h0;
      grp = 4'h0;
      half = pos[0];
      reg_idx = pos[2:1];
      if (op == OP_DUAL_RD || op == OP_DUAL_WR) begin
         half = k[0];
         reg_idx = k[2:1];
         ow = 36'(global_off) + 36'(k[0] ? off1 : off0) + 36'(k[2:1]);
         rel = {ow, 4'h0};
         grp = k[0] ? exec_mask[7:4] : exec_mask[3:0];
      end else if (op == OP_UNAL_RD) begin
         // The offset is already a byte address; its low bits are not forced.
         rel = 40'(global_off) + 40'({k, 4'h0});
         grp = 4'hF;
      end else begin
         ow = 36'(global_off) + 36'(k);
         rel = {ow, 4'h0};
         grp = exec_mask[{pos[1], pos[0], 2'h0} +: 4];
      end
      for (int j = 0; j < 4; j++) begin
         inb[j] = (rel + 40'((j + 1) * 4)) <= limit;
      end
      if (op == OP_BLK_WR || op == OP_DUAL_WR) begin
         acc_en = grp & inb;
         dest_en = 4'h0;
      end else begin
         dest_en = {4{|grp}};
         acc_en = dest_en & inb;
      end
      addr = base + rel[31:0];
   end
endmodule

// ---- dv/obdp_asserts.sv ----
`timescale 1ns/1ps
module obdp_asserts #(
   parameter int unsigned COUNT_W = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic msg_valid,
   input wire logic msg_ready,
   input wire obdp_pkg::obdp_msg_s msg,
   input wire logic wb_valid,
   input wire logic wb_ready,
   input wire obdp_pkg::obdp_wb_s wb,
   input wire logic done_valid,
   input wire obdp_pkg::obdp_done_s done,
   input wire logic mem_req_valid,
   input wire logic mem_req_ready,
   input wire obdp_pkg::obdp_mem_req_s mem_req
);
   import obdp_pkg::*;
   logic [19:0] cd;
   logic ms;
   logic tk;
   assign tk = msg_valid && msg_ready;
   // Remembers the running descriptor and whether memory was touched.
   always_ff @(posedge clk) begin
      if (srst) begin
         cd <= '0;
         ms <= 1'b0;
      end else if (tk) begin
         cd <= msg.desc;
         ms <= 1'b0;
      end else if (mem_req_valid) begin
         ms <= 1'b1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   take_busy_a: assert property (tk |=> !msg_ready)
      else $error("ready high after take");
   wb_hold_a: assert property (
      wb_valid && !wb_ready |=> wb_valid && $stable(wb))
      else $error("writeback dropped early");
   mreq_hold_a: assert property (
      mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
      else $error("memory request dropped early");
   done_pulse_a: assert property (done_valid |=> !done_valid)
      else $error("done longer than one cycle");
   rd_nowrite_a: assert property (mem_req_valid && !cd[16] |-> !mem_req.we)
      else $error("write during read message");
   wr_write_a: assert property (
      mem_req_valid && cd[16:13] == MT_BLK_WR |-> mem_req.we)
      else $error("read during block write");
   ow_align_a: assert property (
      mem_req_valid && cd[16:13] != MT_UNAL_RD |-> mem_req.addr[3:0] == 4'h0)
      else $error("aligned message off OWord");
   err_time_a: assert property (
      tk && msg.desc[16:13] == MT_BLK_RD && msg.desc[10:8] > BS_EIGHT
      |-> ##2 done_valid && done.err)
      else $error("reserved size not flagged in time");
   err_nomem_a: assert property (done_valid && done.err |-> !ms)
      else $error("memory used by refused message");
   commit_a: assert property (
      done_valid && !done.err |-> done.commit == (cd[16] && cd[17]))
      else $error("commit flag wrong");
   wb_read_a: assert property (wb_valid |-> !cd[16])
      else $error("writeback for a write");
   cover property (tk && msg.desc[16:13] == MT_DUAL_RD);
   cover property (done_valid && done.commit);
   cover property (wb_valid && wb.dw_en == 8'hF0);
endmodule

bind obdp_top obdp_asserts #(.COUNT_W(COUNT_W)) u_chk (.clk(clk),
   .srst(srst), .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg),
   .wb_valid(wb_valid), .wb_ready(wb_ready), .wb(wb),
   .done_valid(done_valid), .done(done), .mem_req_valid(mem_req_valid),
   .mem_req_ready(mem_req_ready), .mem_req(mem_req));

// ---- dv/obdp_mem_model.sv ----
`timescale 1ns/1ps
module obdp_mem_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic slow,
   input wire logic mem_req_valid,
   output logic mem_req_ready,
   input wire obdp_pkg::obdp_mem_req_s mem_req,
   output logic mem_rvalid,
   output logic [127:0] mem_rdata
);
   import obdp_pkg::*;
   logic [31:0] mem_dw [256];
   logic tgl;
   int i;
   initial begin
      for (int j = 0; j < 256; j++) begin
         mem_dw[j] = 32'hC0DE_0000 | 32'(j);
      end
   end
   assign mem_req_ready = !slow || tgl;
   // Flat byte addressing of one untiled buffer.
   always @(posedge clk) begin
      tgl <= srst ? 1'b0 : !tgl;
      mem_rvalid <= 1'b0;
      mem_rdata <= srst ? '0 : ~mem_rdata;
      if (!srst && mem_req_valid && mem_req_ready) begin
         i = int'(mem_req.addr[9:2]);
         for (int d = 0; d < 4; d++) begin
            if (mem_req.we && mem_req.dw_en[d]) begin
               mem_dw[i + d] <= mem_req.wdata[32 * d +: 32];
            end
            mem_rdata[32 * d +: 32] <= mem_dw[i + d];
         end
         mem_rvalid <= !mem_req.we;
      end
   end
endmodule

// ---- dv/obdp_top_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
   err_total++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module obdp_top_test;
   import obdp_pkg::*;
   logic clk = 0, srst = 1, msg_valid = 0, wb_ready = 0, slow = 0;
   logic msg_ready, wb_valid, done_valid, mem_req_valid, mem_req_ready;
   logic mem_rvalid;
   logic [127:0] mem_rdata;
   obdp_msg_s msg = '0;
   obdp_wb_s wb;
   obdp_done_s done, dn;
   obdp_mem_req_s mem_req;
   obdp_apb_req_s apb_req = '0;
   obdp_apb_rsp_s apb_rsp;
   logic [255:0] wbd [4];
   logic [7:0] wbe [4];
   logic [31:0] rd;
   logic e;
   int nwb, nmr, err_total = 0, tests_run = 0;
   always #10 clk = !clk;
   obdp_top #(.COUNT_W(16)) DUT (.clk(clk), .srst(srst),
      .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg),
      .wb_valid(wb_valid), .wb_ready(wb_ready), .wb(wb),
      .done_valid(done_valid), .done(done), .mem_req_valid(mem_req_valid),
      .mem_req_ready(mem_req_ready), .mem_req(mem_req),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .apb_req(apb_req),
      .apb_rsp(apb_rsp));
   obdp_mem_model u_mem (.clk(clk), .srst(srst), .slow(slow),
      .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
      .mem_req(mem_req), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   function automatic logic [31:0] dv(input int i);
      return i < 32 ? 32'hC0DE_0000 | 32'(i) : 32'h0;
   endfunction
   function automatic logic [127:0] owd(input int d);
      return {dv(d + 3), dv(d + 2), dv(d + 1), dv(d)};
   endfunction
   function automatic logic [19:0] dsc(input logic [3:0] t,
         input logic [2:0] s, input logic c);
      return {2'h0, c, t, 2'h0, s, 8'h00};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] wd);
      int t;
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (apb_rsp.pready !== 1'b1 && t < 20);
      if (t >= 20) err_total++;
      rd = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic send(input logic [19:0] d, input logic [31:0] g,
         input logic [15:0] m, input logic [255:0] p0, p1);
      int t;
      wbd = '{default: '0};
      wbe = '{default: '0};
      nwb = 0;
      nmr = 0;
      @(posedge clk);
      msg_valid <= 1'b1;
      msg <= {d, g, m, 768'h0, p1, p0};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (msg_ready !== 1'b1 && t < 50);
      msg_valid <= 1'b0;
      t = 0;
      do begin
         @(posedge clk);
         wb_ready <= !wb_ready;
         if ((wb_valid & wb_ready) === 1'b1) begin
            wbd[wb.idx] = wb.data;
            wbe[wb.idx] = wb.dw_en;
            nwb++;
         end
         if ((mem_req_valid & mem_req_ready) === 1'b1) nmr++;
         t++;
      end while (done_valid !== 1'b1 && t < 400);
      dn = done;
      `CHK("done_seen", 1'b1, done_valid)
   endtask
   task automatic t_regs;
      apb(0, REG_SURF_BASE, 0);
      `CHK("base_rst", SURF_BASE_RST, rd)
      apb(0, REG_SURF_ELEMS, 0);
      `CHK("elems_rst", SURF_ELEMS_RST, rd)
      apb(1, REG_SURF_ELEMS, 32'h8);
      apb(1, REG_MSG_COUNT, 32'hFFFF_FFFF);
      apb(0, REG_SURF_ELEMS, 0);
      `CHK("elems", 32'h8, rd)
      apb(0, REG_MSG_COUNT, 0);
      `CHK("count_ro", 32'h0, rd)
      apb(0, 12'h010, 0);
      `CHK("unmapped", 1'b1, e)
   endtask
   task automatic t_rd(input logic [3:0] ty, input logic [2:0] s,
         input logic [31:0] g, input int n, hi, d0);
      logic [7:0] ee [4];
      int r, h;
      ee = '{default: '0};
      send(dsc(ty, s, 1'b1), g, ty == MT_UNAL_RD ? 16'h0 : 16'hFFFF, 0, 0);
      `CHK("wb_count", (n + hi + 1) / 2, nwb)
      for (int k = 0; k < n; k++) begin
         r = (k + hi) / 2;
         h = (k + hi) % 2;
         ee[r][4 * h +: 4] = 4'hF;
         `CHK("wb_data", owd(d0 + 4 * k), wbd[r][128 * h +: 128])
      end
      for (int q = 0; q < (n + hi + 1) / 2; q++) begin
         `CHK("wb_en", ee[q], wbe[q])
      end
   endtask
   task automatic t_dual;
      send(dsc(MT_DUAL_RD, 3'h2, 0), 2, 16'h000F,
         {96'h0, 32'h3, 96'h0, 32'h1}, 0);
      `CHK("dual_reqs", 4, nmr)
      for (int r = 0; r < 4; r++) begin
         `CHK("dual_lo", owd(12 + 4 * r), wbd[r][127:0])
         `CHK("dual_en", 8'h0F, wbe[r])
      end
      send(dsc(MT_DUAL_RD, 3'h0, 0), 2, 16'h00FF,
         {96'h0, 32'h1, 96'h0, 32'h1}, 0);
      `CHK("same_reqs", 1, nmr)
      `CHK("same_data", {owd(12), owd(12)}, wbd[0])
      `CHK("same_en", 8'hFF, wbe[0])
   endtask
   task automatic t_wr;
      send(dsc(MT_BLK_WR, BS_ONE_HI, 1), 2, 16'hFFFF,
         {{4{32'h1111_1111}}, {4{32'h2222_2222}}}, 0);
      `CHK("hi_wr", 32'h1111_1111, u_mem.mem_dw[11])
      `CHK("commit", 1'b1, dn.commit)
      `CHK("wr_nowb", 0, nwb)
      send(dsc(MT_BLK_WR, BS_TWO, 0), 7, 16'hFFFF,
         {{4{32'h3333_3333}}, {4{32'h4444_4444}}}, 0);
      `CHK("lo_wr", 32'h4444_4444, u_mem.mem_dw[28])
      `CHK("oob_wr", 32'hC0DE_0020, u_mem.mem_dw[32])
      `CHK("no_commit", 1'b0, dn.commit)
      // The two blocks do not overlap.
      send(dsc(MT_DUAL_WR, 3'h0, 1), 1, 16'h005A,
         {96'h0, 32'h4, 96'h0, 32'h0},
         {{4{32'h5555_5555}}, {4{32'h6666_6666}}});
      `CHK("dw_on0", 32'h6666_6666, u_mem.mem_dw[5])
      `CHK("dw_off0", 32'hC0DE_0004, u_mem.mem_dw[4])
      `CHK("dw_on1", 32'h5555_5555, u_mem.mem_dw[20])
      `CHK("dw_off1", 32'hC0DE_0015, u_mem.mem_dw[21])
   endtask
   task automatic t_err;
      logic [19:0] bad [3];
      bad = '{dsc(MT_BLK_RD, 3'h5, 0), dsc(MT_DUAL_RD, 3'h1, 0),
         dsc(4'h1, BS_ONE_LO, 0)};
      foreach (bad[j]) begin
         send(bad[j], 0, 16'hFFFF, 0, 0);
         `CHK("err", 1'b1, dn.err)
         `CHK("err_mem", 0, nmr + nwb)
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_regs;
      // The render cache is taken to be in read/write mode already.
      // Block sizes 1 to 8, no six-OWord size.
      t_rd(MT_BLK_RD, BS_ONE_LO, 3, 1, 0, 12);
      t_rd(MT_BLK_RD, BS_ONE_HI, 3, 1, 1, 12);
      t_rd(MT_BLK_RD, BS_TWO, 0, 2, 0, 0);
      t_rd(MT_BLK_RD, BS_FOUR, 6, 4, 0, 24);
      t_rd(MT_BLK_RD, BS_EIGHT, 0, 8, 0, 0);
      slow <= 1'b1;
      t_rd(MT_UNAL_RD, BS_TWO, 20, 2, 0, 5);
      t_rd(MT_UNAL_RD, BS_ONE_HI, 8, 1, 1, 2);
      t_dual;
      t_wr;
      slow <= 1'b0;
      t_err;
      apb(0, REG_STATUS, 0);
      `CHK("status", 32'h2, rd)
      apb(0, REG_MSG_COUNT, 0);
      `CHK("msg_count", 32'hF, rd)
      final_report;
   end
endmodule
